// *** shared/supervisor_pkg.sv ***
// Constants, register map and carrier types for the battery pack supervisor.
// What this block does
// - Both bus lines low two seconds: sleep
// - Either bus line high clears bus-off, wakes
// - Sample presence each second; low means present
// - Shutdown input falling edge turns both switches off
// - Next falling edge or timeout restores switches
// - Pack above 1V means load removed
// - Load-detect source current selectable 10 to 40uA
// - Stack minus pack above 0.1V: charger removed
// - Persistent fault: detection results gate switch re-enable
// - First failure copies three latest safety records
// - Then up to three more failure records
// - First permanent failure forces lifetime log update
// - Every ten hours write log if different
// - Secondary permanent failure drives the fuse output
// - Two host thresholds; crossing raises trip interrupt
// - Thermistor trip raises failure unless monitoring disabled
// - Low cell voltage disables auxiliary regulator output
// - Seven temperature, three voltage ranges with hysteresis
// - Temperature out of range: inhibit or suspend, charge alarm
// - Broadcast compensated charge voltage and current values
// - Device is master of broadcasts, optional PEC
// - Pre-charge and zero-volt charging supported
package supervisor_pkg;

  // Timing
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned SYSTEM_PRESENCE_INPUT_PERIOD_S = 1;
  localparam int unsigned SEC_CYC = SYSTEM_PRESENCE_INPUT_PERIOD_S * CLK_HZ;
  localparam int unsigned BUS_OFF_S = 2;
  localparam int unsigned BUS_OFF_CYC = BUS_OFF_S * CLK_HZ;
  localparam int unsigned LOG_HOURS = 10;
  localparam logic [15:0] LOG_TICKS = 16'(LOG_HOURS * 3600);

  // Sizes
  localparam int NT = 7;
  localparam int NV = 3;
  localparam int BB_N = 6;
  localparam int HIST_N = 3;

  // Register byte offsets
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_TRIP = 12'h008;
  localparam logic [11:0] ADDR_AUX = 12'h00c;
  localparam logic [11:0] ADDR_HYST = 12'h010;
  localparam logic [11:0] ADDR_TEMP_TH = 12'h020;
  localparam logic [11:0] ADDR_VOLT_TH = 12'h038;
  localparam logic [11:0] ADDR_CUR_TAB = 12'h040;
  localparam logic [11:0] ADDR_VOLT_TAB = 12'h060;
  localparam logic [11:0] ADDR_PRE_CUR = 12'h06c;
  localparam logic [11:0] ADDR_BBOX = 12'h080;

  // Field positions
  localparam int CTRL_PEC = 0;
  localparam int CTRL_LDSEL = 1;
  localparam int CTRL_TMO = 8;
  localparam int HYST_VOLT = 16;

  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0a00;
  localparam logic [15:0] TRIP_RST = 16'h0a05;
  localparam logic [15:0] AUX_RST = 16'h0a8c;
  localparam logic [31:0] HYST_RST = 32'h0032_0014;

  typedef enum logic [1:0] {
    BC_IDLE = 2'b00,
    BC_VOLT = 2'b01,
    BC_CURR = 2'b10
  } bcast_state_t;

  typedef struct packed {
    logic is_current;
    logic pec_en;
    logic [15:0] value;
  } bcast_t;

endpackage

// *** core/sync2.sv ***
// Two-stage synchroniser for asynchronous pins.
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // First stage is read only by the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// *** core/range_hyst.sv ***
// Range classifier with hysteresis in both directions, one step per clock.
`timescale 1ns/1ps
module range_hyst #(
  parameter int N = 7,
  parameter int W = 16,
  parameter int IW = 3,
  parameter logic [2:0] RST_IDX = 3'h0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Measurement and limits
  input wire logic [W-1:0] value,
  input wire logic [(N-1)*W-1:0] thresholds,
  input wire logic [W-1:0] hyst,
  output logic [IW-1:0] range_idx
);
  logic [W-1:0] th [N];
  logic [W:0] up_lvl;
  logic [W:0] val_hi;

  // Top slot is a dummy so indexing never runs past the table
  genvar g;
  generate
    for (g = 0; g < N - 1; g++) begin : g_th
      assign th[g] = thresholds[g*W +: W];
    end
  endgenerate
  assign th[N-1] = '1;

  assign up_lvl = {1'b0, th[range_idx]} + {1'b0, hyst};
  assign val_hi = {1'b0, value} + {1'b0, hyst};

  // Leave a range only once past its edge by the hysteresis band
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      range_idx <= IW'(RST_IDX);
    end else if (range_idx < IW'(N - 1) && {1'b0, value} > up_lvl) begin
      range_idx <= range_idx + 1'b1;
    end else if (range_idx != '0 && val_hi < {1'b0, th[range_idx - 1'b1]}) begin
      range_idx <= range_idx - 1'b1;
    end
  end
endmodule

// *** core/battery_pack_supervisor.sv ***
// Supervisory control: bus-off, presence, shutdown, failures, charge control.
`timescale 1ns/1ps
module battery_pack_supervisor
  import supervisor_pkg::*;
#(
  parameter int unsigned SEC_CYC_P = SEC_CYC,
  parameter int unsigned BUS_OFF_CYC_P = BUS_OFF_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins and comparators from outside the clock domain
  input wire logic serial_clock_pin,
  input wire logic serial_data_pin,
  input wire logic system_presence_input,
  input wire logic emergency_off_input,
  input wire logic thermistor_trip_input,
  input wire logic thermistor_trip_enable,
  input wire logic load_cmp_high,
  input wire logic charger_cmp_high,
  // Measurements and events from gauge logic
  input wire logic [15:0] cell_min_mv,
  input wire logic [15:0] cell_max_mv,
  input wire logic [15:0] pack_temp,
  input wire logic [7:0] relative_charge_level,
  input wire logic [15:0] safety_status,
  input wire logic safety_valid,
  input wire logic [14:0] secondary_fail,
  input wire logic fault_active,
  input wire logic [15:0] lifelog_ram_sig,
  input wire logic [15:0] lifelog_nv_sig,
  // Broadcast master handshake
  input wire logic bcast_ready,
  output logic bcast_valid,
  output bcast_t bcast,
  // Control outputs
  output logic charge_switch_drive,
  output logic discharge_switch_drive,
  output logic fuse_drive,
  output logic trip_point_interrupt,
  output logic aux_out_enable,
  output logic sleep_mode,
  output logic system_present,
  output logic load_removed,
  output logic charger_removed,
  output logic [1:0] ld_current_sel,
  output logic lifelog_write,
  output logic charge_inhibit,
  output logic charge_suspend,
  output logic charge_alarm,
  output logic discharge_alarm
);

  // Address falls into a block of n words starting at base
  function automatic logic in_block(input logic [11:0] a, input logic [11:0] base,
                                    input int n);
    in_block = (a >= base) && (a < base + 12'(4 * n)) && (a[1:0] == 2'b00);
  endfunction

  function automatic int widx(input logic [11:0] a, input logic [11:0] base);
    widx = int'((a - base) >> 2);
  endfunction

  // Synchronised pins
  logic [7:0] pins_s;
  logic scl_s, sda_s, system_presence_input_s, eoff_s, ptc_s, ptc_en_s, ld_s, cd_s;
  sync2 #(.W(8)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({serial_clock_pin, serial_data_pin, system_presence_input, emergency_off_input,
        thermistor_trip_input, thermistor_trip_enable, load_cmp_high, charger_cmp_high}),
    .q(pins_s)
  );
  assign {scl_s, sda_s, system_presence_input_s, eoff_s, ptc_s, ptc_en_s, ld_s, cd_s} = pins_s;

  // Software registers
  logic [31:0] ctrl_reg, hyst_reg;
  logic [15:0] trip_reg, aux_reg, pre_reg;
  logic [15:0] temp_th_reg [NT-1];
  logic [15:0] volt_th_reg [NV-1];
  logic [15:0] cur_tab_reg [NT];
  logic [15:0] volt_tab_reg [NV];
  logic [15:0] hist_reg [HIST_N];
  logic [15:0] bbox_reg [BB_N];

  // APB: no wait state; read data is flopped in the setup cycle
  logic apb_setup, apb_write, apb_hit;
  logic [31:0] rdata_next;
  logic [31:0] status_word;
  assign apb_setup = psel && !penable && !pready;
  assign apb_write = psel && penable && pready && pwrite && !pslverr;

  // Decode and read mux
  always_comb begin
    rdata_next = '0;
    apb_hit = 1'b1;
    if (paddr == ADDR_CTRL) rdata_next = ctrl_reg;
    else if (paddr == ADDR_STATUS) rdata_next = status_word;
    else if (paddr == ADDR_TRIP) rdata_next = {16'h0000, trip_reg};
    else if (paddr == ADDR_AUX) rdata_next = {16'h0000, aux_reg};
    else if (paddr == ADDR_HYST) rdata_next = hyst_reg;
    else if (paddr == ADDR_PRE_CUR) rdata_next = {16'h0000, pre_reg};
    else if (in_block(paddr, ADDR_TEMP_TH, NT - 1))
      rdata_next = {16'h0000, temp_th_reg[widx(paddr, ADDR_TEMP_TH)]};
    else if (in_block(paddr, ADDR_VOLT_TH, NV - 1))
      rdata_next = {16'h0000, volt_th_reg[widx(paddr, ADDR_VOLT_TH)]};
    else if (in_block(paddr, ADDR_CUR_TAB, NT))
      rdata_next = {16'h0000, cur_tab_reg[widx(paddr, ADDR_CUR_TAB)]};
    else if (in_block(paddr, ADDR_VOLT_TAB, NV))
      rdata_next = {16'h0000, volt_tab_reg[widx(paddr, ADDR_VOLT_TAB)]};
    else if (in_block(paddr, ADDR_BBOX, BB_N))
      rdata_next = {16'h0000, bbox_reg[widx(paddr, ADDR_BBOX)]};
    else apb_hit = 1'b0;
  end

  // Answer phase flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup && !apb_hit;
      if (apb_setup) prdata <= pwrite ? 32'h0000_0000 : rdata_next;
    end
  end

  // Writable registers; status and black box are read only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RST;
      trip_reg <= TRIP_RST;
      aux_reg <= AUX_RST;
      hyst_reg <= HYST_RST;
      pre_reg <= '0;
      for (int i = 0; i < NT - 1; i++) temp_th_reg[i] <= '0;
      for (int i = 0; i < NV - 1; i++) volt_th_reg[i] <= '0;
      for (int i = 0; i < NT; i++) cur_tab_reg[i] <= '0;
      for (int i = 0; i < NV; i++) volt_tab_reg[i] <= '0;
    end else if (apb_write) begin
      if (paddr == ADDR_CTRL) ctrl_reg <= pwdata;
      if (paddr == ADDR_TRIP) trip_reg <= pwdata[15:0];
      if (paddr == ADDR_AUX) aux_reg <= pwdata[15:0];
      if (paddr == ADDR_HYST) hyst_reg <= pwdata;
      if (paddr == ADDR_PRE_CUR) pre_reg <= pwdata[15:0];
      if (in_block(paddr, ADDR_TEMP_TH, NT - 1))
        temp_th_reg[widx(paddr, ADDR_TEMP_TH)] <= pwdata[15:0];
      if (in_block(paddr, ADDR_VOLT_TH, NV - 1))
        volt_th_reg[widx(paddr, ADDR_VOLT_TH)] <= pwdata[15:0];
      if (in_block(paddr, ADDR_CUR_TAB, NT))
        cur_tab_reg[widx(paddr, ADDR_CUR_TAB)] <= pwdata[15:0];
      if (in_block(paddr, ADDR_VOLT_TAB, NV))
        volt_tab_reg[widx(paddr, ADDR_VOLT_TAB)] <= pwdata[15:0];
    end
  end

  // Second tick shared by presence, shutdown timeout and log timer
  logic [31:0] sec_cnt_reg;
  logic sec_tick;
  assign sec_tick = (sec_cnt_reg == SEC_CYC_P - 1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sec_cnt_reg <= '0;
    else sec_cnt_reg <= sec_tick ? 32'h0000_0000 : sec_cnt_reg + 32'h0000_0001;
  end

  // Bus-off: both lines low for the full window
  logic [31:0] busoff_cnt_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busoff_cnt_reg <= '0;
      sleep_mode <= 1'b0;
    end else if (scl_s || sda_s) begin
      busoff_cnt_reg <= '0;
      sleep_mode <= 1'b0;
    end else if (busoff_cnt_reg >= BUS_OFF_CYC_P - 1) begin
      sleep_mode <= 1'b1;
    end else begin
      busoff_cnt_reg <= busoff_cnt_reg + 32'h0000_0001;
    end
  end

  // Presence sampled once a second; a held-low pin means host attached
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) system_present <= 1'b0;
    else if (sec_tick) system_present <= !system_presence_input_s;
  end

  // Detection comparators; the source current level just goes out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_removed <= 1'b0;
      charger_removed <= 1'b0;
      ld_current_sel <= 2'h0;
    end else begin
      load_removed <= ld_s;
      charger_removed <= cd_s;
      ld_current_sel <= ctrl_reg[CTRL_LDSEL +: 2];
    end
  end

  // Emergency shutdown: toggle on falling edges, or time out
  logic eoff_d_reg, eoff_fall, sd_off_reg;
  logic [7:0] sd_secs_reg;
  logic [7:0] sd_limit;
  assign eoff_fall = eoff_d_reg && !eoff_s;
  assign sd_limit = ctrl_reg[CTRL_TMO +: 8];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eoff_d_reg <= 1'b0; // Matches the synchroniser's reset, so no false edge
      sd_off_reg <= 1'b0;
      sd_secs_reg <= '0;
    end else begin
      eoff_d_reg <= eoff_s;
      if (eoff_fall) begin
        sd_off_reg <= !sd_off_reg;
        sd_secs_reg <= '0;
      end else if (sd_off_reg && sec_tick) begin
        sd_secs_reg <= sd_secs_reg + 8'h01;
        // Zero limit means no timeout
        if (sd_limit != 8'h00 && sd_secs_reg + 8'h01 >= sd_limit) sd_off_reg <= 1'b0;
      end
    end
  end

  // Fault hold released only when both detectors see nothing attached
  logic fault_hold_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) fault_hold_reg <= 1'b0;
    else if (fault_active) fault_hold_reg <= 1'b1;
    else if (load_removed && charger_removed) fault_hold_reg <= 1'b0;
  end

  // Permanent failure: latched until reset
  logic [15:0] pf_vec;
  logic [15:0] pf_seen_reg;
  logic pf_event, pf_first, pf_more;
  logic [1:0] bb_more_reg;
  assign pf_vec = {ptc_en_s && ptc_s, secondary_fail};
  assign pf_event = |pf_vec;
  assign pf_first = pf_event && !fuse_drive;
  assign pf_more = fuse_drive && |(pf_vec & ~pf_seen_reg);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_drive <= 1'b0;
      pf_seen_reg <= '0;
    end else begin
      if (pf_event) fuse_drive <= 1'b1;
      pf_seen_reg <= pf_seen_reg | pf_vec;
    end
  end

  // Safety history and black box
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < HIST_N; i++) hist_reg[i] <= '0;
      for (int i = 0; i < BB_N; i++) bbox_reg[i] <= '0;
      bb_more_reg <= '0;
    end else begin
      if (safety_valid) begin
        hist_reg[0] <= safety_status;
        for (int i = 1; i < HIST_N; i++) hist_reg[i] <= hist_reg[i-1];
      end
      if (pf_first) begin
        for (int i = 0; i < HIST_N; i++) bbox_reg[i] <= hist_reg[i];
      end else if (pf_more && bb_more_reg < 2'd3) begin
        bbox_reg[HIST_N + int'(bb_more_reg)] <= pf_vec & ~pf_seen_reg;
        bb_more_reg <= bb_more_reg + 2'd1;
      end
    end
  end

  // Lifetime log: on first failure at once, else every ten hours if stale
  logic [15:0] log_secs_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      log_secs_reg <= '0;
      lifelog_write <= 1'b0;
    end else begin
      lifelog_write <= 1'b0;
      if (sec_tick) begin
        if (log_secs_reg == LOG_TICKS - 16'h0001) begin
          log_secs_reg <= '0;
          lifelog_write <= lifelog_ram_sig != lifelog_nv_sig;
        end else begin
          log_secs_reg <= log_secs_reg + 16'h0001;
        end
      end
      if (pf_first) lifelog_write <= 1'b1;
    end
  end

  // Trip point: set on downward crossing, cleared by rewriting thresholds
  logic [7:0] relative_charge_level_d_reg;
  logic trip_cross;
  assign trip_cross = (relative_charge_level_d_reg > trip_reg[7:0] && relative_charge_level <= trip_reg[7:0])
    || (relative_charge_level_d_reg > trip_reg[15:8] && relative_charge_level <= trip_reg[15:8]);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relative_charge_level_d_reg <= 8'hff;
      trip_point_interrupt <= 1'b0;
    end else begin
      relative_charge_level_d_reg <= relative_charge_level;
      if (trip_cross) trip_point_interrupt <= 1'b1;
      else if (apb_write && paddr == ADDR_TRIP) trip_point_interrupt <= 1'b0;
    end
  end

  // Auxiliary output cut on low cell
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) aux_out_enable <= 1'b0;
    else aux_out_enable <= !(cell_min_mv < aux_reg);
  end

  // Range classification
  logic [2:0] t_rng;
  logic [1:0] v_rng;
  logic [(NT-1)*16-1:0] t_th_flat;
  logic [(NV-1)*16-1:0] v_th_flat;
  always_comb begin
    for (int i = 0; i < NT - 1; i++) t_th_flat[i*16 +: 16] = temp_th_reg[i];
    for (int i = 0; i < NV - 1; i++) v_th_flat[i*16 +: 16] = volt_th_reg[i];
  end
  range_hyst #(.N(NT), .W(16), .IW(3), .RST_IDX(3'h3)) u_temp_rng (
    .pclk(pclk),
    .presetn(presetn),
    .value(pack_temp),
    .thresholds(t_th_flat),
    .hyst({8'h00, hyst_reg[7:0]}),
    .range_idx(t_rng)
  );
  range_hyst #(.N(NV), .W(16), .IW(2), .RST_IDX(3'h1)) u_volt_rng (
    .pclk(pclk),
    .presetn(presetn),
    .value(cell_max_mv),
    .thresholds(v_th_flat),
    .hyst(hyst_reg[HYST_VOLT +: 16]),
    .range_idx(v_rng)
  );

  // Outermost temperature ranges stop charging
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      charge_inhibit <= 1'b0;
      charge_suspend <= 1'b0;
      charge_alarm <= 1'b0;
      discharge_alarm <= 1'b0;
    end else begin
      charge_inhibit <= (t_rng == 3'd0);
      charge_suspend <= (t_rng == 3'(NT - 1));
      charge_alarm <= charge_inhibit || charge_suspend || fuse_drive;
      discharge_alarm <= fault_hold_reg || fuse_drive;
    end
  end

  // Switch drivers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      charge_switch_drive <= 1'b0;
      discharge_switch_drive <= 1'b0;
    end else begin
      charge_switch_drive <= !fuse_drive && !sd_off_reg && !fault_hold_reg
        && !charge_inhibit && !charge_suspend;
      discharge_switch_drive <= !fuse_drive && !sd_off_reg && !fault_hold_reg;
    end
  end

  // Lowest voltage range uses the pre-charge current, down to zero volts
  logic [15:0] chg_cur;
  assign chg_cur = (charge_inhibit || charge_suspend || fuse_drive) ? 16'h0000
    : (v_rng == 2'd0) ? pre_reg : cur_tab_reg[t_rng];

  // Broadcast voltage then current every second
  bcast_state_t bc_state_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bc_state_reg <= BC_IDLE;
      bcast_valid <= 1'b0;
      bcast <= '0;
    end else begin
      case (bc_state_reg)
        BC_IDLE: begin
          if (sec_tick) begin
            bc_state_reg <= BC_VOLT;
            bcast_valid <= 1'b1;
            bcast <= '{is_current: 1'b0, pec_en: ctrl_reg[CTRL_PEC],
                       value: volt_tab_reg[v_rng]};
          end
        end
        BC_VOLT: begin
          if (bcast_ready) begin
            bc_state_reg <= BC_CURR;
            bcast <= '{is_current: 1'b1, pec_en: ctrl_reg[CTRL_PEC], value: chg_cur};
          end
        end
        BC_CURR: begin
          if (bcast_ready) begin
            bc_state_reg <= BC_IDLE;
            bcast_valid <= 1'b0;
          end
        end
        default: begin
          bc_state_reg <= BC_IDLE;
          bcast_valid <= 1'b0;
        end
      endcase
    end
  end

  assign status_word = {15'h0000, bb_more_reg, trip_point_interrupt, charge_suspend,
                        charge_inhibit, v_rng, 1'b0, t_rng, sd_off_reg, fuse_drive,
                        charger_removed, load_removed, system_present, sleep_mode};

  // Checks
  chk_busoff_sleep: assert property (@(posedge pclk) disable iff (!presetn)
    (!scl_s && !sda_s && busoff_cnt_reg == BUS_OFF_CYC_P - 1) |=> sleep_mode)
    else $error("bus-off did not enter sleep");
  chk_bus_wake: assert property (@(posedge pclk) disable iff (!presetn)
    (sleep_mode && (scl_s || sda_s)) |=> !sleep_mode)
    else $error("bus activity did not wake");
  chk_shutdown_off: assert property (@(posedge pclk) disable iff (!presetn)
    (eoff_fall && !sd_off_reg) |=> sd_off_reg ##1 (!charge_switch_drive && !discharge_switch_drive))
    else $error("shutdown edge left a switch on");
  chk_fuse_latch: assert property (@(posedge pclk) disable iff (!presetn)
    fuse_drive |=> fuse_drive && !charge_switch_drive && !discharge_switch_drive)
    else $error("permanent failure not held");
  chk_ptc_fail: assert property (@(posedge pclk) disable iff (!presetn)
    (ptc_en_s && ptc_s) |=> fuse_drive)
    else $error("thermistor trip not latched");
  chk_pf_log: assert property (@(posedge pclk) disable iff (!presetn)
    pf_first |=> lifelog_write && bbox_reg[0] == $past(hist_reg[0]))
    else $error("failure did not log or copy history");
  chk_trip_int: assert property (@(posedge pclk) disable iff (!presetn)
    trip_cross |=> trip_point_interrupt)
    else $error("trip crossing missed");
  chk_aux_cut: assert property (@(posedge pclk) disable iff (!presetn)
    (cell_min_mv < aux_reg) |=> !aux_out_enable)
    else $error("aux output stayed on at low cell");
  chk_inhibit_chg: assert property (@(posedge pclk) disable iff (!presetn)
    (t_rng == 3'd0) |=> charge_inhibit ##1 !charge_switch_drive)
    else $error("cold range did not stop charging");
  chk_secondary_fuse: assert property (@(posedge pclk) disable iff (!presetn)
    (|secondary_fail) |=> fuse_drive)
    else $error("secondary failure did not drive fuse");
  chk_fault_hold: assert property (@(posedge pclk) disable iff (!presetn)
    fault_hold_reg |=> !discharge_switch_drive)
    else $error("fault hold left discharge on");

endmodule

// *** verif/smb_host_model.sv ***
// Smart charger and host line model on the far side of the supervisor.
`timescale 1ns/1ps
module smb_host_model
  import supervisor_pkg::*;
(
  // Clock
  input wire logic pclk,
  // Broadcast handshake
  input wire logic bcast_valid,
  input wire bcast_t bcast,
  output logic bcast_ready = 1'b0,
  // Bus lines and their control
  input wire logic bus_hold_low,
  output logic serial_clock_pin,
  output logic serial_data_pin
);
  int wait_n = 0;
  // Pull-ups keep idle lines high; host parks both low on request
  assign serial_clock_pin = !bus_hold_low;
  assign serial_data_pin = !bus_hold_low;
  // Charger stalls each word so the hold of both words is exercised
  always @(posedge pclk) begin
    wait_n <= (bcast_valid && !bcast_ready) ? wait_n + 1 : 0;
    bcast_ready <= bcast_valid && !bcast_ready && wait_n == 2;
  end
endmodule

// *** verif/battery_pack_supervisor_tb_top.sv ***
// Self-checking bench for the battery pack supervisor.
`timescale 1ns/1ps
module battery_pack_supervisor_tb_top;
  import supervisor_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic rerr;
  logic serial_clock_pin, serial_data_pin, bus_hold_low = 0, system_presence_input = 1;
  logic emergency_off_input = 1, thermistor_trip_input = 0, thermistor_trip_enable = 0;
  logic load_cmp_high = 0, charger_cmp_high = 0, safety_valid = 0, fault_active = 0;
  logic [15:0] cell_min_mv = 16'h0e10, cell_max_mv = 16'h0e10, pack_temp = 16'h0000;
  logic [15:0] safety_status = 16'h0001, lifelog_ram_sig = 0, lifelog_nv_sig = 0;
  logic [7:0] relative_charge_level = 8'h64;
  logic [14:0] secondary_fail = 0;
  logic bcast_ready, bcast_valid, charge_switch_drive, discharge_switch_drive, fuse_drive;
  logic trip_point_interrupt, aux_out_enable, sleep_mode, system_present, load_removed;
  logic charger_removed, lifelog_write, charge_inhibit, charge_suspend, charge_alarm;
  logic discharge_alarm;
  logic [1:0] ld_current_sel;
  bcast_t bcast;
  int n_mismatch = 0, samples_checked = 0, cyc = 0;
  battery_pack_supervisor #(.SEC_CYC_P(20), .BUS_OFF_CYC_P(40)) i_battery_pack_supervisor (.*);
  smb_host_model i_smb_host_model (.*);
  // Clock at 40 MHz
  always #12.5 pclk = ~pclk;
  // Hang guard: whole run needs a few hundred cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; waits for pready without assuming latency
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    rerr = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic t_regs();
    apb(0, ADDR_CTRL, 0); chk(rd, CTRL_RST);
    apb(0, ADDR_TRIP, 0); chk(rd, {16'h0, TRIP_RST});
    apb(0, 12'hffc, 0); chk({31'h0, rerr}, 1); // unmapped word answers with error
    $display("test registers done");
  endtask
  task automatic t_shutdown();
    emergency_off_input <= 0; wt(8); chk(discharge_switch_drive, 0);
    chk(charge_switch_drive, 0);
    emergency_off_input <= 1; wt(4); emergency_off_input <= 0; wt(8);
    chk(discharge_switch_drive, 1);
    emergency_off_input <= 1; wt(4); emergency_off_input <= 0; wt(8);
    chk(discharge_switch_drive, 0);
    emergency_off_input <= 1; wt(260); chk(discharge_switch_drive, 1);
    $display("test shutdown done");
  endtask
  task automatic t_bus_off();
    bus_hold_low <= 1; wt(30); chk(sleep_mode, 0);
    wt(25); chk(sleep_mode, 1);
    bus_hold_low <= 0; wt(6); chk(sleep_mode, 0);
    $display("test bus off done");
  endtask
  task automatic t_misc();
    system_presence_input <= 0; wt(50); chk(system_present, 1);
    fault_active <= 1; wt(4); chk(discharge_switch_drive, 0);
    fault_active <= 0; wt(4); chk(discharge_switch_drive, 0);
    load_cmp_high <= 1; charger_cmp_high <= 1; wt(10);
    chk(load_removed, 1);
    chk(charger_removed, 1);
    chk(discharge_switch_drive, 1);
    apb(1, ADDR_CTRL, 32'h0000_0a06); wt(2); chk(ld_current_sel, 3);
    chk(aux_out_enable, 1);
    cell_min_mv <= 16'h0a00; wt(2); chk(aux_out_enable, 0);
    // Dropping to 6 crosses the upper threshold of 10
    relative_charge_level <= 8'h06; wt(3); chk(trip_point_interrupt, 1);
    apb(1, ADDR_TRIP, {16'h0, TRIP_RST}); wt(1); chk(trip_point_interrupt, 0);
    relative_charge_level <= 8'h05; wt(5); chk(trip_point_interrupt, 1);
    $display("test presence load trip done");
  endtask
  task automatic t_bcast();
    apb(1, ADDR_VOLT_TAB + 12'h008, 32'h0000_41a0);
    // Let any broadcast in flight finish, then catch a fresh one
    wait (bcast_valid === 1'b0);
    wait (bcast_valid === 1'b1);
    chk(bcast.is_current, 0);
    chk(bcast.value, 16'h41a0);
    @(posedge pclk iff bcast_ready === 1'b1); wt(1); chk(bcast.is_current, 1);
    $display("test broadcast done");
  endtask
  task automatic t_temp();
    for (int i = 0; i < 3; i++) apb(1, ADDR_TEMP_TH + 12'(4 * i), 32'h0000_0100);
    wt(8); chk(charge_inhibit, 1);
    chk(charge_switch_drive, 0);
    chk(charge_alarm, 1);
    chk(discharge_switch_drive, 1);
    $display("test temperature done");
  endtask
  task automatic t_fuse();
    thermistor_trip_input <= 1; safety_valid <= 1; wt(1); safety_valid <= 0; wt(6);
    chk(fuse_drive, 0);
    secondary_fail <= 15'h0004; wt(2); secondary_fail <= 0; wt(8);
    chk(fuse_drive, 1);
    chk(discharge_switch_drive, 0);
    apb(0, ADDR_BBOX, 0); chk(rd, 32'h0000_0001);
    thermistor_trip_enable <= 1; wt(6);
    apb(0, ADDR_BBOX + 12'h00c, 0); chk(rd, 32'h0000_8000);
    apb(1, ADDR_CTRL, CTRL_RST); wt(20); chk(fuse_drive, 1);
    $display("test fuse done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    wt(8); presetn <= 1; wt(2);
    t_regs(); t_shutdown(); t_bus_off(); t_misc(); t_bcast(); t_temp(); t_fuse();
    tally_and_finish();
  end
endmodule
